//--- hdl/aisc_defines.svh
/*
  Offsets, limits, reset values and timing counts of the analogue input scaling block.
  Assumes a 32-bit AXI4-Lite register window with byte addresses of 8 bits.
*/
`ifndef AISC_DEFINES_SVH
`define AISC_DEFINES_SVH

`define AISC_OFF_FUNC     8'h00
`define AISC_OFF_LOW0     8'h04
`define AISC_OFF_STRIDE   8'h08
`define AISC_OFF_DELAY    8'h1C
`define AISC_OFF_ACTION   8'h20
`define AISC_OFF_STATUS   8'h24
`define AISC_OFF_REFSUM   8'h28
`define AISC_OFF_FBSUM    8'h2C

`define AISC_V_MAX        16'h03E8
`define AISC_I_MAX        16'h07D0
`define AISC_V_ARM        16'h0064
`define AISC_I_ARM        16'h00C8
`define AISC_THERM_OHM    16'h0BB8
`define AISC_FULL         16'h2710

`define AISC_LOW_DEF_V    16'h0000
`define AISC_LOW_DEF_I    16'h0190
`define AISC_DELAY_MIN    7'h01
`define AISC_DELAY_MAX    7'h63
`define AISC_DELAY_DEF    7'h0A
`define AISC_ACTION_MAX   3'h5

`define AISC_TICK_S       1
`define AISC_CLK_HZ       100000000
`define AISC_TICK_CYCLES  (`AISC_TICK_S * `AISC_CLK_HZ)

`define AISC_RESP_OKAY    2'h0
`define AISC_RESP_SLVERR  2'h2

`endif

//--- hdl/aisc_pkg.sv
/*
  Types of the analogue input scaling block.
  Assumes aisc_defines.svh is compiled alongside.
*/
`default_nettype none

package aisc_pkg;

  typedef logic [1:0] aisc_func_t;
  localparam aisc_func_t FN_NONE  = 2'h0;
  localparam aisc_func_t FN_REF   = 2'h1;
  localparam aisc_func_t FN_FB    = 2'h2;
  localparam aisc_func_t FN_THERM = 2'h3;

  typedef logic [2:0] aisc_action_t;

  typedef struct packed {
    aisc_func_t  func;
    logic [15:0] low;
    logic [15:0] high;
  } aisc_in_cfg_t;

  typedef struct packed {
    logic        therm_stop;
    logic [2:0]  loss;
    logic        bus_ovr;
    aisc_action_t action;
  } aisc_status_t;

endpackage

`default_nettype wire

//--- hdl/aisc_top.sv
/*
  Analogue input configuration, linear scaling and signal-loss supervision for
  two voltage inputs and one current input, with an AXI4-Lite register slave.
  Assumes digitised samples synchronous to aclk: volts in 10 mV steps, milliamps
  in 10 uA steps, and ohms for an input set to thermistor.
*/
`timescale 1ns/100ps
`default_nettype none
`include "aisc_defines.svh"

module aisc_top #(
  parameter int TICK_CYCLES = `AISC_TICK_CYCLES
) (
  input  wire logic                 aclk,            // Control clock
  input  wire logic                 aresetn,         // Sync reset, active low
  input  wire logic [7:0]           s_axi_awaddr,    // Write address
  input  wire logic                 s_axi_awvalid,   // Write address valid
  output logic                      s_axi_awready,   // Write address ready
  input  wire logic [31:0]          s_axi_wdata,     // Write data
  input  wire logic [3:0]           s_axi_wstrb,     // Byte strobes
  input  wire logic                 s_axi_wvalid,    // Write data valid
  output logic                      s_axi_wready,    // Write data ready
  output logic [1:0]                s_axi_bresp,     // Write response
  output logic                      s_axi_bvalid,    // Write response valid
  input  wire logic                 s_axi_bready,    // Write response ready
  input  wire logic [7:0]           s_axi_araddr,    // Read address
  input  wire logic                 s_axi_arvalid,   // Read address valid
  output logic                      s_axi_arready,   // Read address ready
  output logic [31:0]               s_axi_rdata,     // Read data
  output logic [1:0]                s_axi_rresp,     // Read response
  output logic                      s_axi_rvalid,    // Read data valid
  input  wire logic                 s_axi_rready,    // Read data ready
  input  wire logic [15:0]          volt_a_sample,   // Voltage input A sample
  input  wire logic [15:0]          volt_b_sample,   // Voltage input B sample
  input  wire logic [15:0]          current_sample,  // Current input sample
  input  wire logic                 bus_timeout,     // Fieldbus time-out level
  input  wire aisc_pkg::aisc_action_t bus_action,    // Fieldbus time-out action
  output logic [17:0]               ref_total,       // Summed scaled reference
  output logic [17:0]               feedback_total,  // Summed scaled feedback
  output logic                      thermistor_stop, // Motor stop request
  output aisc_pkg::aisc_action_t    applied_action   // Fallback action in force
);

  // Tick counter is 27 bits wide
  if (TICK_CYCLES < 1 || TICK_CYCLES > 134217727) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  aisc_pkg::aisc_in_cfg_t cfg [3];
  logic [6:0]             signal_loss_delay;
  aisc_pkg::aisc_action_t signal_loss_action;
  logic [26:0]            tick_cnt;
  logic [15:0]            scaled [3];
  logic [6:0]             loss_cnt [3];
  logic [2:0]             loss_hit;
  logic                   bus_ovr;

  // AXI write: both halves taken together, so arrival order is free
  wire        wr_take   = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire        rd_take   = s_axi_arvalid && !s_axi_rvalid;
  wire [7:0]  wa        = s_axi_awaddr;
  wire [7:0]  ra        = s_axi_araddr;
  wire        wr_full   = wr_take && (s_axi_wstrb == 4'hF);
  wire        wa_cfg    = (wa >= `AISC_OFF_LOW0) && (wa < `AISC_OFF_DELAY);
  wire        wa_hit    = (wa == `AISC_OFF_FUNC) || wa_cfg || (wa == `AISC_OFF_DELAY)
                          || (wa == `AISC_OFF_ACTION);
  wire        ra_cfg    = (ra >= `AISC_OFF_LOW0) && (ra < `AISC_OFF_DELAY);
  wire        ra_hit    = (ra <= `AISC_OFF_FBSUM) && (ra[1:0] == 2'h0);
  wire [1:0]  ra_sel    = 2'((ra - `AISC_OFF_LOW0) >> 3);
  wire        ra_high   = ra[2] == 1'b0;
  // Clamp on the whole word so large values saturate instead of wrapping
  wire [6:0]  next_delay = (s_axi_wdata < 32'(`AISC_DELAY_MIN)) ? `AISC_DELAY_MIN :
                           (s_axi_wdata > 32'(`AISC_DELAY_MAX)) ? `AISC_DELAY_MAX :
                           s_axi_wdata[6:0];
  wire        tick      = (tick_cnt == 27'(TICK_CYCLES - 1));

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;

  function automatic logic [15:0] aisc_scale(input logic [15:0] x, input logic [15:0] lo,
                                             input logic [15:0] hi);
    logic [31:0] num;
    logic [31:0] q;
    num = 32'h0;
    q   = 32'h0;
    if (hi <= lo) begin
      aisc_scale = (x >= hi) ? `AISC_FULL : 16'h0000;
    end else if (x <= lo) begin
      aisc_scale = 16'h0000;
    end else if (x >= hi) begin
      aisc_scale = `AISC_FULL;
    end else begin
      num = 32'(x - lo) * 32'(`AISC_FULL);
      q   = num / 32'(hi - lo);
      aisc_scale = q[15:0];
    end
  endfunction

  aisc_pkg::aisc_status_t status;
  assign status = '{therm_stop: thermistor_stop, loss: loss_hit, bus_ovr: bus_ovr,
                    action: applied_action};
  wire aisc_pkg::aisc_in_cfg_t rcfg = cfg[ra_sel];
  wire [31:0] rd_mux =
      (ra == `AISC_OFF_FUNC)   ? {26'h0, cfg[2].func, cfg[1].func, cfg[0].func} :
      ra_cfg                   ? {16'h0, ra_high ? rcfg.high : rcfg.low} :
      (ra == `AISC_OFF_DELAY)  ? {25'h0, signal_loss_delay} :
      (ra == `AISC_OFF_ACTION) ? {29'h0, signal_loss_action} :
      (ra == `AISC_OFF_STATUS) ? {24'h0, status} :
      (ra == `AISC_OFF_REFSUM) ? {14'h0, ref_total} :
      (ra == `AISC_OFF_FBSUM)  ? {14'h0, feedback_total} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AISC_RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wa_hit ? `AISC_RESP_OKAY : `AISC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `AISC_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= ra_hit ? `AISC_RESP_OKAY : `AISC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      signal_loss_delay  <= `AISC_DELAY_DEF;
      signal_loss_action <= 3'h0;
    end else begin
      if (wr_full && wa == `AISC_OFF_DELAY) begin
        signal_loss_delay <= next_delay;
      end
      if (wr_full && wa == `AISC_OFF_ACTION && s_axi_wdata <= 32'(`AISC_ACTION_MAX)) begin
        signal_loss_action <= s_axi_wdata[2:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt <= 27'h0;
    end else begin
      tick_cnt <= tick_cnt + 27'h1;
    end
  end

  logic [17:0] ref_part [4];
  logic [17:0] fb_part  [4];
  assign ref_part[0] = 18'h0;
  assign fb_part[0]  = 18'h0;

  for (genvar i = 0; i < 3; i++) begin : g_in
    localparam logic [15:0] MAXV   = (i == 2) ? `AISC_I_MAX : `AISC_V_MAX;
    localparam logic [15:0] ARM    = (i == 2) ? `AISC_I_ARM : `AISC_V_ARM;
    localparam logic [15:0] LOWDEF = (i == 2) ? `AISC_LOW_DEF_I : `AISC_LOW_DEF_V;
    localparam aisc_pkg::aisc_func_t FNDEF = (i == 1) ? aisc_pkg::FN_NONE : aisc_pkg::FN_REF;
    localparam logic [7:0]  LOWOFF = 8'(`AISC_OFF_LOW0 + i * `AISC_OFF_STRIDE);
    wire logic [15:0] x = (i == 0) ? volt_a_sample : (i == 1) ? volt_b_sample : current_sample;
    wire logic [1:0]  wfn = s_axi_wdata[2*i +: 2];
    wire logic [15:0] wval = (s_axi_wdata > 32'(MAXV)) ? MAXV : s_axi_wdata[15:0];
    // Thermistor code is refused on the current input
    wire logic fn_ok = !(i == 2 && wfn == aisc_pkg::FN_THERM);
    wire logic sup = cfg[i].func == aisc_pkg::FN_REF || cfg[i].func == aisc_pkg::FN_FB;
    wire logic armed = cfg[i].low > ARM;
    wire logic below = {1'b0, x, 1'b0} < {2'b0, cfg[i].low};

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg[i] <= '{func: FNDEF, low: LOWDEF, high: MAXV};
      end else begin
        if (wr_full && wa == `AISC_OFF_FUNC && fn_ok) begin
          cfg[i].func <= wfn;
        end
        if (wr_full && wa == LOWOFF) begin
          cfg[i].low <= wval;
        end
        if (wr_full && wa == 8'(LOWOFF + 8'h04)) begin
          cfg[i].high <= wval;
        end
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        scaled[i] <= 16'h0000;
      end else begin
        scaled[i] <= aisc_scale(x, cfg[i].low, cfg[i].high);
      end
    end

    // Count whole seconds; cleared as soon as the signal recovers
    always_ff @(posedge aclk) begin
      if (!aresetn || !(sup && armed && below)) begin
        loss_cnt[i] <= 7'h00;
        loss_hit[i] <= 1'b0;
      end else if (loss_cnt[i] >= signal_loss_delay) begin
        loss_hit[i] <= 1'b1;
      end else if (tick) begin
        loss_cnt[i] <= loss_cnt[i] + 7'h01;
      end
    end

    assign ref_part[i+1] = ref_part[i] +
        ((cfg[i].func == aisc_pkg::FN_REF) ? {2'b00, scaled[i]} : 18'h0);
    assign fb_part[i+1] = fb_part[i] +
        ((cfg[i].func == aisc_pkg::FN_FB) ? {2'b00, scaled[i]} : 18'h0);
  end

  wire therm_a = cfg[0].func == aisc_pkg::FN_THERM && volt_a_sample > `AISC_THERM_OHM;
  wire therm_b = cfg[1].func == aisc_pkg::FN_THERM && volt_b_sample > `AISC_THERM_OHM;
  wire loss_any = |loss_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_total       <= 18'h0;
      feedback_total  <= 18'h0;
      thermistor_stop <= 1'b0;
      applied_action  <= 3'h0;
      bus_ovr         <= 1'b0;
    end else begin
      ref_total       <= ref_part[3];
      feedback_total  <= fb_part[3];
      thermistor_stop <= therm_a || therm_b;
      bus_ovr         <= bus_timeout && !loss_any;
      // Analogue loss decides even when its action is off
      applied_action  <= loss_any ? signal_loss_action :
                         bus_timeout ? bus_action : 3'h0;
    end
  end

  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence

  sequence s_loss_due;
    g_in[0].sup && g_in[0].armed && g_in[0].below && loss_cnt[0] >= signal_loss_delay;
  endsequence

  property p_wr_resp;
    @(posedge aclk) disable iff (!aresetn)
      s_wr_take |=> s_axi_bvalid && !s_axi_awready;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write not answered next cycle");

  property p_rd_resp;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read not answered");

  property p_wr_done;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write response not released");

  property p_rd_done;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read data not released");

  property p_limits;
    @(posedge aclk) disable iff (!aresetn)
      signal_loss_delay >= `AISC_DELAY_MIN && signal_loss_delay <= `AISC_DELAY_MAX
      && signal_loss_action <= `AISC_ACTION_MAX;
  endproperty
  a_limits: assert property (p_limits) else $error("delay or action out of range");

  property p_therm;
    @(posedge aclk) disable iff (!aresetn)
      therm_a |=> thermistor_stop;
  endproperty
  a_therm: assert property (p_therm) else $error("thermistor stop missing");

  property p_loss_fire;
    @(posedge aclk) disable iff (!aresetn)
      s_loss_due ##1 s_loss_due |-> loss_hit[0] ##1 (applied_action == $past(signal_loss_action));
  endproperty
  a_loss_fire: assert property (p_loss_fire) else $error("signal loss not acted on");

  property p_unarmed;
    @(posedge aclk) disable iff (!aresetn)
      !g_in[0].armed |=> !loss_hit[0];
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("loss flagged while unarmed");

  property p_priority;
    @(posedge aclk) disable iff (!aresetn)
      loss_any && bus_timeout |=> applied_action == $past(signal_loss_action);
  endproperty
  a_priority: assert property (p_priority) else $error("bus action beat analogue loss");

  property p_bus_only;
    @(posedge aclk) disable iff (!aresetn)
      !loss_any && bus_timeout |=> applied_action == $past(bus_action) && bus_ovr;
  endproperty
  a_bus_only: assert property (p_bus_only) else $error("bus action not applied");

  property p_no_therm_current;
    @(posedge aclk) disable iff (!aresetn)
      cfg[2].func != aisc_pkg::FN_THERM;
  endproperty
  a_no_therm_current: assert property (p_no_therm_current) else $error("current thermistor");

  property p_ranges;
    @(posedge aclk) disable iff (!aresetn)
      cfg[0].low <= `AISC_V_MAX && cfg[1].high <= `AISC_V_MAX && cfg[2].low <= `AISC_I_MAX;
  endproperty
  a_ranges: assert property (p_ranges) else $error("scaling point out of range");

  property p_defaults;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> cfg[2].func == aisc_pkg::FN_REF && cfg[1].func == aisc_pkg::FN_NONE
                         && cfg[2].low == `AISC_LOW_DEF_I && signal_loss_delay == `AISC_DELAY_DEF;
  endproperty
  a_defaults: assert property (p_defaults) else $error("reset defaults wrong");

endmodule

`default_nettype wire

//--- test/aisc_source.sv
/*
  Model of the digitised analogue sources feeding the three inputs.
  Assumes the bench sets target levels; slow mode slews 64 counts a cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module aisc_source (
  input  wire logic        aclk,           // Control clock
  input  wire logic        slow,           // Slew instead of stepping
  input  wire logic [15:0] tgt_a,          // Target, voltage A
  input  wire logic [15:0] tgt_b,          // Target, voltage B
  input  wire logic [15:0] tgt_c,          // Target, current
  output logic      [15:0] volt_a_sample,  // Voltage A sample
  output logic      [15:0] volt_b_sample,  // Voltage B sample
  output logic      [15:0] current_sample  // Current sample
);
  function automatic logic [15:0] slew(input logic [15:0] cur, input logic [15:0] tgt,
                                       input logic s);
    if (!s || ((cur > tgt) ? cur - tgt : tgt - cur) <= 16'h0040) return tgt;
    return (cur > tgt) ? cur - 16'h0040 : cur + 16'h0040;
  endfunction

  // A real sensor drifts; slow mode makes loss onset gradual
  always @(posedge aclk) begin
    volt_a_sample <= slew(volt_a_sample, tgt_a, slow);
    volt_b_sample <= slew(volt_b_sample, tgt_b, slow);
    current_sample <= slew(current_sample, tgt_c, slow);
  end
endmodule

`default_nettype wire

//--- test/testbench.sv
/*
  Self-checking bench for aisc_top: register defaults and clamps, scaling,
  sums, thermistor stop and signal-loss fallback over AXI4-Lite.
  Assumes aisc_source for the samples and a short tick for the delay.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bus_timeout = 1'b0, thermistor_stop;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] tgt_a = 16'h0, tgt_b = 16'h0, tgt_c = 16'h0, sa, sb, sc;
  logic [17:0] ref_total, feedback_total;
  aisc_pkg::aisc_action_t bus_action = 3'h0, applied_action;
  int fail_count = 0, n_checks = 0;

  always #5 aclk = ~aclk;

  aisc_source aisc_source_i (.aclk(aclk), .slow(slow), .tgt_a(tgt_a), .tgt_b(tgt_b),
    .tgt_c(tgt_c), .volt_a_sample(sa), .volt_b_sample(sb), .current_sample(sc));

  aisc_top #(.TICK_CYCLES(10)) aisc_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .volt_a_sample(sa), .volt_b_sample(sb), .current_sample(sc), .bus_timeout(bus_timeout),
    .bus_action(bus_action), .ref_total(ref_total), .feedback_total(feedback_total),
    .thermistor_stop(thermistor_stop), .applied_action(applied_action));

  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask

  task automatic wait_chk(input int n, input string name, input logic [31:0] exp,
                          input logic [31:0] which);
    repeat (n) @(posedge aclk);
    case (which)
      0: chk(name, exp, {14'h0, ref_total});
      1: chk(name, exp, {14'h0, feedback_total});
      2: chk(name, exp, {31'h0, thermistor_stop});
      default: chk(name, exp, {29'h0, applied_action});
    endcase
  endtask

  localparam logic [7:0]  DEF_ADDR [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                                           8'h18, 8'h1C, 8'h20};
  localparam logic [31:0] DEF_VAL [9] = '{32'h11, 32'h0, 32'h3E8, 32'h0, 32'h3E8, 32'h190,
                                          32'h7D0, 32'h0A, 32'h0};

  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 9; i++) rchk("reset value", DEF_ADDR[i], DEF_VAL[i]);
    rchk("unmapped read", 8'h30, 32'h0);
    chk("unmapped read resp", 32'h2, {30'h0, resp});
    wr(8'h24, 32'h0);
    chk("read-only write resp", 32'h2, {30'h0, resp});
    // Defaults: A and current are references, B ignored
    tgt_a <= 16'h01F4;
    tgt_b <= 16'h02BC;
    tgt_c <= 16'h04B0;
    wait_chk(6, "ref sum", 32'h2710, 0);
    rchk("ref sum register", 8'h28, 32'h2710);
    wr(8'h00, 32'h1A);
    wait_chk(6, "feedback sum", 32'h2EE0, 1);
    wait_chk(0, "ref after change", 32'h1388, 0);
    rchk("feedback register", 8'h2C, 32'h2EE0);
    wr(8'h00, 32'h33);
    rchk("current therm refused", 8'h00, 32'h13);
    tgt_a <= 16'h0BB8;
    wait_chk(6, "therm at limit", 32'h0, 2);
    wait_chk(0, "therm not ref", 32'h1388, 0);
    tgt_a <= 16'h0BB9;
    wait_chk(6, "therm over limit", 32'h1, 2);
    wr(8'h04, 32'h7D0);
    rchk("volt low clamp", 8'h04, 32'h3E8);
    wr(8'h14, 32'h900);
    rchk("current low clamp", 8'h14, 32'h7D0);
    wr(8'h1C, 32'h0);
    rchk("delay floor", 8'h1C, 32'h1);
    wr(8'h1C, 32'hC8);
    rchk("delay ceiling", 8'h1C, 32'h63);
    // Signal loss on A with a bus time-out pending
    tgt_a <= 16'h01F4;
    wr(8'h00, 32'h01);
    wr(8'h04, 32'hC8);
    wr(8'h1C, 32'h2);
    wr(8'h20, 32'h2);
    bus_timeout <= 1'b1;
    bus_action <= 3'h4;
    wait_chk(4, "bus action alone", 32'h4, 3);
    slow <= 1'b1;
    tgt_a <= 16'h0032;
    wait_chk(5, "loss not yet", 32'h4, 3);
    wait_chk(75, "loss beats bus", 32'h2, 3);
    rchk("status in loss", 8'h24, 32'h12);
    for (int c = 0; c < 6; c++) begin
      wr(8'h20, c);
      wait_chk(3, "action code", c, 3);
    end
    wr(8'h20, 32'h6);
    wait_chk(3, "bad action refused", 32'h5, 3);
    tgt_a <= 16'h01F4;
    wait_chk(20, "loss cleared", 32'h4, 3);
    bus_timeout <= 1'b0;
    slow <= 1'b0;
    wait_chk(3, "idle action", 32'h0, 3);
    wr(8'h04, 32'h64);
    tgt_a <= 16'h0000;
    wait_chk(60, "unarmed at 1 V", 32'h0, 3);
    wr(8'h04, 32'h65);
    wait_chk(60, "armed above 1 V", 32'h5, 3);
    give_verdict();
  end
endmodule

`default_nettype wire
